// [common/trip_defines.svh]
// trip supervisor constants: register map, fields, limits, times
// assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef TRIP_DEFINES_SVH
`define TRIP_DEFINES_SVH

// fault sources, index is the fixed priority rank (0 highest)
`define NSRC        12
`define SRC_OC      0
`define SRC_GND     1
`define SRC_OV      2
`define SRC_LV2     3
`define SRC_DOL     4
`define SRC_ETH     5
`define SRC_OPH     6
`define SRC_IPH     7
`define SRC_MOL     8
`define SRC_UL      9
`define SRC_NM      10
`define SRC_LV      11
// two bits per source, level=00 latch=01 fatal=11
`define KIND_DEFAULT 24'h155555

// register byte addresses
`define REG_CTRL    6'h00
`define REG_PARAM_A 6'h04
`define REG_PARAM_B 6'h08
`define REG_WARNSEL 6'h0C
`define REG_ACTIVE  6'h10
`define REG_STATUS  6'h14
`define REG_MASK    6'h18
`define REG_DISPLAY 6'h1C
`define REG_WARNMSG 6'h20

// field positions
`define F_RESET     0
`define F_OL_EN     7:0
`define F_UL_EN     15:8
`define F_TH_EN     23:16
`define F_NM_EN     31:24
`define F_PHASE     7:0
`define F_OL_LVL    15:8
`define F_UL_LVL    23:16
`define F_TH_LVL    31:24
`define B_OUT_PHASE 1
`define B_IN_PHASE  2
`define NM_ON       8'h01

// limits in percent of rated value
`define OC_LIMIT    9'h0C8
`define DOL_LOW     9'h096
`define DOL_HIGH    9'h0C8

// times
`define CLK_MHZ     40
`define TICK_US     1000
`define DOL_LOW_S   60
`define DOL_HIGH_S  4
`define ETH_S       60
`define SEQ_W       8

`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define RESET_A     32'h0000_0000
`define RESET_B     32'h0000_0000

`endif

// [common/trip_pkg.sv]
// trip supervisor types: fault kinds, sensed inputs, display codes
// assumes trip_defines.svh is found on the include path
package trip_pkg;
`include "trip_defines.svh"

   typedef enum logic [1:0] {
      KIND_LEVEL = 2'h0,
      KIND_LATCH = 2'h1,
      KIND_FATAL = 2'h3
   } fault_kind_t;

   typedef struct packed {
      logic       running;
      logic [8:0] current_pct;
      logic [8:0] load_pct;
      logic       bus_over;
      logic       bus_under;
      logic       gnd_over;
      logic       out_phase_open;
      logic       in_phase_open;
      logic       motor_absent;
   } sense_t;

   typedef struct packed {
      logic [3:0] seg_code;
      logic [3:0] detail_code;
   } disp_t;

endpackage : trip_pkg

// [rtl/load_timer.sv]
// inverse-time accumulator: counts ticks while over, unwinds while not
// assumes tick_i is a one-cycle pulse on clk_i
`timescale 1ns/1ps
`default_nettype none

module load_timer #(
   parameter int unsigned LIMIT = 60000,
   parameter int unsigned W     = $clog2(LIMIT + 1)
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic tick_i,
   input  wire logic over_i,
   output logic      expired_o
);
   localparam logic [W-1:0] LIM = W'(LIMIT);

   logic [W-1:0] cnt_r;
   logic         exp_r;

   wire up = tick_i & over_i & (cnt_r != LIM);
   wire dn = tick_i & ~over_i & (cnt_r != '0);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= '0;
         exp_r <= 1'b0;
      end else begin
         if (up) cnt_r <= cnt_r + 1'b1;
         else if (dn) cnt_r <= cnt_r - 1'b1;
         exp_r <= (cnt_r == LIM);
      end
   end

   assign expired_o = exp_r;
endmodule : load_timer

`default_nettype wire

// [rtl/drive_trip_supervisor.sv]
// drive fault supervisor: trips, warnings, display, AXI4-Lite registers
// assumes sense_i is synchronous to clk_i; fault_reset_i is an async pin
//
// What this block does
// [R1] enabled faults halt drive or raise warning
// [R2] level faults self-clear, never logged
// [R3] latch faults hold until reset input
// [R4] fatal faults clear only at power-up
// [R5] segment shows priority, detail shows first
// [R6] current warning readable as message register
// [R7] motor overload trips when enabled, over level
// [R8] underload trips when enabled, under level
// [R9] overcurrent trips above twice rated current
// [R10] overvoltage trips above bus limit
// [R11] undervoltage level, running undervoltage latch
// [R12] ground fault omitted on small units
// [R13] thermal trip only when enabled
// [R14] output open phase, phase bit one
// [R15] input open phase, phase bit two
// [R16] drive overload 150% 1min, 200% 4s
// [R17] no-motor trip when enable equals one
// [R18] arrival stamp and fixed rank per source
`timescale 1ns/1ps
`default_nettype none

`include "trip_defines.svh"

module drive_trip_supervisor #(
   parameter logic [2*`NSRC-1:0] KIND_MAP = `KIND_DEFAULT,
   parameter bit          HAS_GROUND = 1'b1,
   parameter int unsigned TICK_CYC   = `TICK_US * `CLK_MHZ,
   parameter int unsigned DOL_LO_TK  = `DOL_LOW_S * 1000000 / `TICK_US,
   parameter int unsigned DOL_HI_TK  = `DOL_HIGH_S * 1000000 / `TICK_US,
   parameter int unsigned ETH_TK     = `ETH_S * 1000000 / `TICK_US
) (
   input  wire logic            clk_i,
   input  wire logic            rst_b_i,
   input  wire logic            fault_reset_i,
   input  wire trip_pkg::sense_t sense_i,
   input  wire logic            axi_awvalid_i,
   output logic                 axi_awready_o,
   input  wire logic [5:0]      axi_awaddr_i,
   input  wire logic            axi_wvalid_i,
   output logic                 axi_wready_o,
   input  wire logic [31:0]     axi_wdata_i,
   input  wire logic [3:0]      axi_wstrb_i,
   output logic                 axi_bvalid_o,
   input  wire logic            axi_bready_i,
   output logic [1:0]           axi_bresp_o,
   input  wire logic            axi_arvalid_i,
   output logic                 axi_arready_o,
   input  wire logic [5:0]      axi_araddr_i,
   output logic                 axi_rvalid_o,
   input  wire logic            axi_rready_i,
   output logic [31:0]          axi_rdata_o,
   output logic [1:0]           axi_rresp_o,
   output logic                 trip_o,
   output logic                 warn_o,
   output logic                 irq_o,
   output trip_pkg::disp_t      disp_o
);
   import trip_pkg::*;

   localparam int N = `NSRC;

   ////////////////////////////////////////////////////////////////////
   // register bus slave
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_held_r, w_held_r;
   logic [5:0]  awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;

   wire aw_take = axi_awvalid_i & awready_r;
   wire w_take  = axi_wvalid_i & wready_r;
   wire aw_have = aw_held_r | aw_take;
   wire w_have  = w_held_r | w_take;
   wire do_wr   = aw_have & w_have & ~bvalid_r;
   wire aw_nxt  = aw_have & ~do_wr;
   wire w_nxt   = w_have & ~do_wr;
   wire b_nxt   = do_wr | (bvalid_r & ~axi_bready_i);
   wire ar_take = axi_arvalid_i & arready_r;
   wire r_nxt   = ar_take | (rvalid_r & ~axi_rready_i);

   wire [5:0]  wr_addr = aw_held_r ? awaddr_r : axi_awaddr_i;
   wire [31:0] wr_data = w_held_r ? wdata_r : axi_wdata_i;
   wire [3:0]  wr_strb = w_held_r ? wstrb_r : axi_wstrb_i;
   wire [31:0] wmask   = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                          {8{wr_strb[1]}}, {8{wr_strb[0]}}};

   wire wr_ctrl = do_wr & (wr_addr == `REG_CTRL);
   wire wr_pa   = do_wr & (wr_addr == `REG_PARAM_A);
   wire wr_pb   = do_wr & (wr_addr == `REG_PARAM_B);
   wire wr_ws   = do_wr & (wr_addr == `REG_WARNSEL);
   wire wr_st   = do_wr & (wr_addr == `REG_STATUS);
   wire wr_mk   = do_wr & (wr_addr == `REG_MASK);
   wire wr_hit  = wr_ctrl | wr_pa | wr_pb | wr_ws | wr_st | wr_mk
                | (wr_addr == `REG_ACTIVE) | (wr_addr == `REG_DISPLAY)
                | (wr_addr == `REG_WARNMSG);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else begin
         aw_held_r <= aw_nxt;
         w_held_r  <= w_nxt;
         awready_r <= ~aw_nxt & ~b_nxt;
         wready_r  <= ~w_nxt & ~b_nxt;
         bvalid_r  <= b_nxt;
         if (aw_take) awaddr_r <= axi_awaddr_i;
         if (w_take) begin
            wdata_r <= axi_wdata_i;
            wstrb_r <= axi_wstrb_i;
         end
         if (do_wr) bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // software registers
   logic [31:0]  param_a_r, param_b_r;
   logic [N-1:0] warn_sel_r, status_r, mask_r, active_r;
   logic [3:0]   warn_msg_r;
   disp_t        disp_r;

   wire [7:0] ol_en    = param_a_r[`F_OL_EN];
   wire [7:0] ul_en    = param_a_r[`F_UL_EN];
   wire [7:0] th_en    = param_a_r[`F_TH_EN];
   wire [7:0] nm_en    = param_a_r[`F_NM_EN];
   wire [7:0] phase    = param_b_r[`F_PHASE];
   wire [8:0] ol_lvl   = {1'b0, param_b_r[`F_OL_LVL]};
   wire [8:0] ul_lvl   = {1'b0, param_b_r[`F_UL_LVL]};
   wire [8:0] th_lvl   = {1'b0, param_b_r[`F_TH_LVL]};
   wire [N-1:0] w1c    = wr_st ? (wr_data[N-1:0] & wmask[N-1:0]) : '0;
   wire [N-1:0] mk_new = (mask_r & ~wmask[N-1:0]) | (wr_data[N-1:0] & wmask[N-1:0]);
   wire [N-1:0] ws_new = (warn_sel_r & ~wmask[N-1:0]) | (wr_data[N-1:0] & wmask[N-1:0]);

   wire [5:0]  rd_addr = axi_araddr_i;
   wire [31:0] rd_disp = {20'h0, disp_r.detail_code, 4'h0, disp_r.seg_code};
   wire rd_hit = (rd_addr == `REG_CTRL) | (rd_addr == `REG_PARAM_A)
               | (rd_addr == `REG_PARAM_B) | (rd_addr == `REG_WARNSEL)
               | (rd_addr == `REG_ACTIVE) | (rd_addr == `REG_STATUS)
               | (rd_addr == `REG_MASK) | (rd_addr == `REG_DISPLAY)
               | (rd_addr == `REG_WARNMSG);
   wire [31:0] rd_val =
        (rd_addr == `REG_PARAM_A) ? param_a_r :
        (rd_addr == `REG_PARAM_B) ? param_b_r :
        (rd_addr == `REG_WARNSEL) ? 32'(warn_sel_r) :
        (rd_addr == `REG_ACTIVE)  ? 32'(active_r) :
        (rd_addr == `REG_STATUS)  ? 32'(status_r) :
        (rd_addr == `REG_MASK)    ? 32'(mask_r) :
        (rd_addr == `REG_DISPLAY) ? rd_disp :
        (rd_addr == `REG_WARNMSG) ? 32'(warn_msg_r) : 32'h0;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         param_a_r  <= `RESET_A;
         param_b_r  <= `RESET_B;
         warn_sel_r <= '0;
         mask_r     <= '0;
      end else begin
         if (wr_pa) param_a_r <= (param_a_r & ~wmask) | (wr_data & wmask);
         if (wr_pb) param_b_r <= (param_b_r & ~wmask) | (wr_data & wmask);
         if (wr_ws) warn_sel_r <= ws_new;
         if (wr_mk) mask_r <= mk_new;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `RESP_OKAY;
      end else begin
         arready_r <= ~r_nxt;
         rvalid_r  <= r_nxt;
         if (ar_take) begin
            rdata_r <= rd_val;
            rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // fault-reset pin: three stages, change taken when last two agree
   logic [2:0] fr_s_r;
   logic       fr_lvl_r;

   wire fr_agree = (fr_s_r[1] == fr_s_r[2]);
   wire fr_pulse = fr_agree & fr_s_r[2] & ~fr_lvl_r;
   wire rst_req  = fr_pulse | (wr_ctrl & wr_strb[0] & wr_data[`F_RESET]);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fr_s_r   <= '0;
         fr_lvl_r <= 1'b0;
      end else begin
         fr_s_r <= {fr_s_r[1:0], fault_reset_i};
         if (fr_agree) fr_lvl_r <= fr_s_r[2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // time base and inverse-time overload timers
   logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
   logic                        tick_r;
   logic                        dol_lo_exp, dol_hi_exp, eth_exp;

   // wrap at the last count so the tick period is exactly TICK_CYC
   wire tick_wrap = (tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1));

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_r <= tick_wrap;
         if (tick_wrap) tick_cnt_r <= '0;
         else tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end

   load_timer #(.LIMIT(DOL_LO_TK)) u_dol_lo (               // [R16]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .tick_i(tick_r),
      .over_i(sense_i.current_pct >= `DOL_LOW), .expired_o(dol_lo_exp));
   load_timer #(.LIMIT(DOL_HI_TK)) u_dol_hi (               // [R16]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .tick_i(tick_r),
      .over_i(sense_i.current_pct >= `DOL_HIGH), .expired_o(dol_hi_exp));
   load_timer #(.LIMIT(ETH_TK)) u_eth (                     // [R13]
      .clk_i(clk_i), .rst_b_i(rst_b_i), .tick_i(tick_r),
      .over_i((th_en != 8'h00) & (sense_i.current_pct > th_lvl)),
      .expired_o(eth_exp));

   ////////////////////////////////////////////////////////////////////
   // fault conditions
   logic [N-1:0] cond;

   assign cond[`SRC_OC]  = sense_i.current_pct > `OC_LIMIT;             // [R9]
   assign cond[`SRC_GND] = HAS_GROUND & sense_i.gnd_over;               // [R12]
   assign cond[`SRC_OV]  = sense_i.bus_over;                            // [R10]
   assign cond[`SRC_LV2] = sense_i.bus_under & sense_i.running;         // [R11]
   assign cond[`SRC_DOL] = dol_lo_exp | dol_hi_exp;                     // [R16]
   assign cond[`SRC_ETH] = (th_en != 8'h00) & eth_exp;                  // [R13]
   assign cond[`SRC_OPH] = phase[`B_OUT_PHASE] & sense_i.out_phase_open; // [R14]
   assign cond[`SRC_IPH] = phase[`B_IN_PHASE] & sense_i.in_phase_open;  // [R15]
   assign cond[`SRC_MOL] = (ol_en != 8'h00) & (sense_i.load_pct > ol_lvl); // [R7]
   assign cond[`SRC_UL]  = (ul_en != 8'h00) & (sense_i.load_pct < ul_lvl); // [R8]
   assign cond[`SRC_NM]  = (nm_en == `NM_ON) & sense_i.running
                         & sense_i.motor_absent;                        // [R17]
   assign cond[`SRC_LV]  = sense_i.bus_under;                           // [R11]

   ////////////////////////////////////////////////////////////////////
   // per-source clearing behaviour, history and arrival stamps
   logic [N-1:0]        active_nxt, rise, logged, fatal_mask;
   logic [`SEQ_W-1:0]   stamp_r [N];
   logic [`SEQ_W-1:0]   seq_r;

   for (genvar i = 0; i < N; i++) begin : g_src
      wire fault_kind_t kind = fault_kind_t'(KIND_MAP[2*i +: 2]);
      assign fatal_mask[i] = (kind == KIND_FATAL);
      assign logged[i]     = (kind != KIND_LEVEL);               // [R2]
      assign active_nxt[i] =
           (kind == KIND_LEVEL) ? cond[i] :                      // [R2]
           (kind == KIND_FATAL) ? (cond[i] | active_r[i]) :      // [R4]
           (cond[i] | (active_r[i] & ~rst_req));                 // [R3]
      assign rise[i] = active_nxt[i] & ~active_r[i];

      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            active_r[i] <= 1'b0;
            status_r[i] <= 1'b0;
            stamp_r[i]  <= '0;
         end else begin
            active_r[i] <= active_nxt[i];                        // [R1]
            status_r[i] <= (rise[i] & logged[i]) | (status_r[i] & ~w1c[i]);
            if (rise[i]) stamp_r[i] <= seq_r;                    // [R18]
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) seq_r <= '0;
      else if (active_nxt == '0) seq_r <= '0;
      else if ((|rise) && (seq_r != '1)) seq_r <= seq_r + 1'b1;  // [R18]
   end

   ////////////////////////////////////////////////////////////////////
   // display and warning selection
   wire [N-1:0] trip_vec = active_r & ~warn_sel_r;
   wire [N-1:0] warn_vec = active_r & warn_sel_r;

   logic [3:0]        seg_nxt, det_nxt, wmsg_nxt;
   logic [`SEQ_W-1:0] best;
   logic              found;

   always_comb begin
      seg_nxt  = 4'h0;
      wmsg_nxt = 4'h0;
      det_nxt  = 4'h0;
      best     = '1;
      found    = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (trip_vec[i]) seg_nxt = 4'(i + 1);                   // [R5]
         if (warn_vec[i]) wmsg_nxt = 4'(i + 1);                  // [R6]
      end
      for (int i = 0; i < N; i++) begin
         if (trip_vec[i] && (!found || stamp_r[i] < best)) begin // [R5]
            found   = 1'b1;
            best    = stamp_r[i];
            det_nxt = 4'(i + 1);
         end
      end
   end

   logic trip_r, warn_r, irq_r;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trip_r     <= 1'b0;
         warn_r     <= 1'b0;
         irq_r      <= 1'b0;
         disp_r     <= '0;
         warn_msg_r <= 4'h0;
      end else begin
         trip_r             <= |trip_vec;                        // [R1]
         warn_r             <= |warn_vec;                        // [R1]
         irq_r              <= |(status_r & mask_r);
         disp_r.seg_code    <= seg_nxt;
         disp_r.detail_code <= det_nxt;
         warn_msg_r         <= wmsg_nxt;
      end
   end

   assign axi_awready_o = awready_r;
   assign axi_wready_o  = wready_r;
   assign axi_bvalid_o  = bvalid_r;
   assign axi_bresp_o   = bresp_r;
   assign axi_arready_o = arready_r;
   assign axi_rvalid_o  = rvalid_r;
   assign axi_rdata_o   = rdata_r;
   assign axi_rresp_o   = rresp_r;
   assign trip_o        = trip_r;
   assign warn_o        = warn_r;
   assign irq_o         = irq_r;
   assign disp_o        = disp_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   wire [N-1:0] fatal_act = active_r & fatal_mask;
   wire lv_level  = (KIND_MAP[2*`SRC_LV +: 2] == KIND_LEVEL);
   wire oc_latch  = (KIND_MAP[2*`SRC_OC +: 2] == KIND_LATCH);

   a_trip_halts: assert property (                              // [R1]
      (trip_vec != '0) |=> trip_r)
      else $error("active trip did not halt output");
   a_level_follows: assert property (                           // [R2]
      (lv_level && !cond[`SRC_LV]) |=> !active_r[`SRC_LV])
      else $error("level fault did not self clear");
   a_level_unlogged: assert property (                          // [R2]
      (lv_level && !status_r[`SRC_LV]) |=> !status_r[`SRC_LV])
      else $error("level fault entered history");
   a_latch_holds: assert property (                             // [R3]
      (oc_latch && active_r[`SRC_OC] && !rst_req) |=> active_r[`SRC_OC])
      else $error("latched trip dropped without reset");
   a_latch_clears: assert property (                            // [R3]
      (oc_latch && rst_req && !cond[`SRC_OC]) |=> !active_r[`SRC_OC])
      else $error("latched trip survived reset");
   a_fatal_sticks: assert property (                            // [R4]
      (fatal_act != '0) |=> ((fatal_act & $past(fatal_act)) == $past(fatal_act)))
      else $error("fatal fault cleared");
   a_seg_priority: assert property (                            // [R5]
      trip_vec[`SRC_OC] |=> (disp_r.seg_code == 4'h1))
      else $error("segment code not highest priority");
   a_overcurrent: assert property (                             // [R9]
      (sense_i.current_pct > `OC_LIMIT) |=> active_r[`SRC_OC] ##1 trip_r || warn_r)
      else $error("overcurrent not tripped");
   a_motor_ol: assert property (                                // [R7]
      (ol_en == 8'h00 && !active_r[`SRC_MOL]) |-> !active_nxt[`SRC_MOL]
         || (KIND_MAP[2*`SRC_MOL +: 2] == KIND_LEVEL))
      else $error("motor overload fired while disabled");
   a_run_undervolt: assert property (                           // [R11]
      (sense_i.bus_under && sense_i.running) |=> active_r[`SRC_LV2] && active_r[`SRC_LV])
      else $error("running undervoltage not raised");
   a_out_phase: assert property (                               // [R14]
      (phase[`B_OUT_PHASE] && sense_i.out_phase_open) |=> active_r[`SRC_OPH])
      else $error("output open phase not tripped");
endmodule : drive_trip_supervisor

`default_nettype wire

// [tb/sense_model.sv]
// sensing front end model: presents the requested sense word
// assumes the bench updates requests on clk_i edges
`timescale 1ns/1ps
`default_nettype none
module sense_model (
   input  wire logic             clk_i,
   input  wire trip_pkg::sense_t req_i,
   output trip_pkg::sense_t      sense_o
);
   import trip_pkg::*;
   // one clock of conversion delay
   always_ff @(posedge clk_i) sense_o <= req_i;
endmodule : sense_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the trip supervisor over AXI4-Lite
// assumes trip_pkg is compiled first, defines on the include path
`timescale 1ns/1ps
`default_nettype none
`include "trip_defines.svh"
module testbench;
   import trip_pkg::*;
   logic clk_i = 0;
   logic rst_b_i = 0;
   logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, frst = 0;
   logic [5:0] awa = 0, ara = 0;
   logic [31:0] wd = 0;
   wire awr, wrdy, bv, arr, rv, trip, warn, irq;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   disp_t disp;
   sense_t req = '0;
   sense_t sense;
   int n_errors = 0, check_count = 0, cycles = 0;
   initial forever #12.5 clk_i = ~clk_i;
   sense_model SM (.clk_i(clk_i), .req_i(req), .sense_o(sense));
   drive_trip_supervisor #(.TICK_CYC(4), .DOL_LO_TK(6), .DOL_HI_TK(4), .ETH_TK(5)) DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .fault_reset_i(frst), .sense_i(sense),
      .axi_awvalid_i(awv), .axi_awready_o(awr), .axi_awaddr_i(awa),
      .axi_wvalid_i(wv), .axi_wready_o(wrdy), .axi_wdata_i(wd), .axi_wstrb_i(4'hF),
      .axi_bvalid_o(bv), .axi_bready_i(bre), .axi_bresp_o(br),
      .axi_arvalid_i(arv), .axi_arready_o(arr), .axi_araddr_i(ara),
      .axi_rvalid_o(rv), .axi_rready_i(rre), .axi_rdata_o(rdat), .axi_rresp_o(rr),
      .trip_o(trip), .warn_o(warn), .irq_o(irq), .disp_o(disp));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // trip, warn, irq, segment code, detail code
   task automatic pins(input logic [10:0] e);
      chk({21'h0, trip, warn, irq, disp}, {21'h0, e});
   endtask : pins
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      do begin
         @(posedge clk_i);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
      end while (!bv);
      bre <= 0;
   endtask : wr
   task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk_i);
      ara <= a;
      arv <= 1;
      rre <= 1;
      do begin
         @(posedge clk_i);
         if (arr) arv <= 0;
      end while (!rv);
      rre <= 0;
      chk(rdat, e);
      chk({30'h0, rr}, {30'h0, r});
   endtask : rdc
   // idle sensors, then acknowledge and clear the log
   task automatic clr();
      req <= '0;
      cyc(10);
      wr(`REG_CTRL, 32'h1);
      wr(`REG_STATUS, 32'hFFF);
      cyc(3);
   endtask : clr
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      rst_b_i <= 1;
      rdc(`REG_STATUS, 0, `RESP_OKAY);
      rdc(6'h3C, 0, `RESP_SLVERR);
      wr(`REG_MASK, 32'hFFF);
      req.current_pct <= 9'h0C9;
      cyc(5);
      pins(11'h511);
      wr(`REG_CTRL, 32'h1);
      cyc(3);
      pins(11'h511);
      req.current_pct <= 9'h064;
      cyc(5);
      pins(11'h511);
      wr(`REG_CTRL, 32'h1);
      cyc(3);
      pins(11'h100);
      wr(`REG_STATUS, 32'h1);
      cyc(3);
      pins(11'h000);
      req.bus_under <= 1;
      cyc(5);
      pins(11'h4CC);
      rdc(`REG_STATUS, 0, `RESP_OKAY);
      req.bus_under <= 0;
      cyc(5);
      pins(11'h000);
      req <= '{running: 1'b1, bus_under: 1'b1, default: '0};
      cyc(5);
      pins(11'h544);
      rdc(`REG_STATUS, 32'h8, `RESP_OKAY);
      req <= '0;
      cyc(4);
      pins(11'h544);
      frst <= 1;
      cyc(6);
      pins(11'h100);
      frst <= 0;
      clr();
      req.bus_over <= 1;
      cyc(5);
      req.current_pct <= 9'h0C9;
      cyc(5);
      pins(11'h513);
      clr();
      wr(`REG_WARNSEL, 32'h4);
      req.bus_over <= 1;
      cyc(5);
      chk({30'h0, trip, warn}, 32'h1);
      rdc(`REG_WARNMSG, 32'h3, `RESP_OKAY);
      clr();
      wr(`REG_WARNSEL, 32'h0);
      req <= '{running: 1'b1, load_pct: 9'h0FF, out_phase_open: 1'b1,
               in_phase_open: 1'b1, motor_absent: 1'b1, default: '0};
      cyc(6);
      rdc(`REG_ACTIVE, 0, `RESP_OKAY);
      wr(`REG_PARAM_A, 32'h0200_0000);
      rdc(`REG_ACTIVE, 0, `RESP_OKAY);
      wr(`REG_PARAM_B, 32'h2);
      rdc(`REG_ACTIVE, 32'h040, `RESP_OKAY);
      wr(`REG_PARAM_B, 32'h6);
      rdc(`REG_ACTIVE, 32'h0C0, `RESP_OKAY);
      wr(`REG_PARAM_A, 32'h0100_0001);
      rdc(`REG_ACTIVE, 32'h5C0, `RESP_OKAY);
      wr(`REG_PARAM_A, 32'h0);
      wr(`REG_PARAM_B, 32'h0);
      clr();
      req.current_pct <= 9'h0C8;
      cyc(4);
      rdc(`REG_ACTIVE, 0, `RESP_OKAY);
      cyc(20);
      rdc(`REG_ACTIVE, 32'h010, `RESP_OKAY);
      wr(`REG_MASK, 32'h0);
      cyc(3);
      pins(11'h455);
      clr();
      wr(`REG_PARAM_A, 32'h0001_0000);
      wr(`REG_PARAM_B, 32'h6400_0000);
      req <= '{gnd_over: 1'b1, current_pct: 9'h065, default: '0};
      cyc(3);
      rdc(`REG_ACTIVE, 32'h002, `RESP_OKAY);
      cyc(24);
      rdc(`REG_ACTIVE, 32'h022, `RESP_OKAY);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
